/* dv/hpio_host_model.sv */
`timescale 1ns/1ps
// host computer side: output channel driven on request, input channel answers by itself
module hpio_host_model (
  input wire logic ref_clk,
  input wire logic out_rcvd_pulse,
  input wire logic in_word_ready,
  input wire logic [15:0] in_word,
  output logic [15:0] out_word,
  output logic out_ctl,
  output logic in_ctl,
  output logic init
);
  int in_lag = 1;
  logic [15:0] got = 16'h0000;
  initial begin
    out_word = 16'h0000;
    out_ctl = 1'b0;
    in_ctl = 1'b0;
    init = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic send(input logic [15:0] w, output logic ok);
    int n;
    @(posedge ref_clk);
    #1;
    out_word = w;
    out_ctl = 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (out_rcvd_pulse !== 1'b1 && n < 60);
    ok = n < 60;
  endtask : send
  task automatic release_ctl();
    @(posedge ref_clk);
    #1;
    out_ctl = 1'b0;
    // released lines must not keep showing the last word
    out_word = ~out_word;
  endtask : release_ctl
  //////////////////////////////////////////////////////////////////////////////
  always begin
    @(posedge ref_clk);
    if (in_word_ready === 1'b1) begin
      repeat (in_lag) @(posedge ref_clk);
      got = in_word;
      #1 in_ctl = 1'b1;
      while (in_word_ready === 1'b1) @(posedge ref_clk);
      #1 in_ctl = 1'b0;
    end
  end
endmodule : hpio_host_model

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic REF_CLK = 1'b0;
  logic RESETN = 1'b0;
  // active-high host; the inverting strap is tried last, in t_init
  logic HOST_POL_LOW = 1'b0;
  logic [17:0] BUS_ADDR_IN = 18'h00000;
  logic [15:0] BUS_DATA_IN = 16'h0000;
  logic BUS_WRITE_IN = 1'b0;
  logic BUS_ADDRESS_VALID_IN = 1'b0;
  logic BUS_ACKNOWLEDGE_IN = 1'b0;
  logic BUS_GRANT = 1'b0;
  wire [15:0] HOST_OUTPUT_WORD, HOST_INPUT_WORD, BUS_DATA_OUT;
  wire HOST_OUTPUT_CONTROL, HOST_INPUT_CONTROL, HOST_INIT, IRQ;
  wire OUTPUT_WORD_RECEIVED, OUTPUT_DATA_RECEIVED_PULSE, INPUT_WORD_READY;
  wire NEXT_DATA_READY_PULSE, SYSTEM_RESET_REQ, BUS_REQUEST, BUS_DATA_OE;
  wire BUS_MASTER_OE, BUS_WRITE_OUT, BUS_ADDRESS_VALID_OUT, BUS_ACKNOWLEDGE_OUT;
  wire COUNT_ZERO_LED, COUNT_NONZERO_FLAG;
  wire [17:0] BUS_ADDR_OUT;
  wire [8:0] TRAP_ADDR;
  wire [3:0] STATE_LEDS;
  int n_fail = 0, checks_done = 0, cyc = 0, irq_n = 0, odr_n = 0, next_data_ready_pulse_n = 0;
  int ack_lag = 0, lag = 0, wn = 0;
  logic [17:0] wa [4];
  logic [15:0] wd [4];
  always #10 REF_CLK = ~REF_CLK;
  hpio_port hpio_port_inst (.REF_CLK, .RESETN, .HOST_OUTPUT_WORD, .HOST_OUTPUT_CONTROL,
    .HOST_INPUT_CONTROL, .HOST_INIT, .HOST_POL_LOW, .HOST_INPUT_WORD, .OUTPUT_WORD_RECEIVED,
    .OUTPUT_DATA_RECEIVED_PULSE, .INPUT_WORD_READY, .NEXT_DATA_READY_PULSE, .SYSTEM_RESET_REQ,
    .BUS_ADDR_IN, .BUS_DATA_IN, .BUS_WRITE_IN, .BUS_ADDRESS_VALID_IN, .BUS_ACKNOWLEDGE_IN,
    .BUS_GRANT, .BUS_REQUEST, .BUS_ADDR_OUT, .BUS_DATA_OUT, .BUS_DATA_OE, .BUS_MASTER_OE,
    .BUS_WRITE_OUT, .BUS_ADDRESS_VALID_OUT, .BUS_ACKNOWLEDGE_OUT, .IRQ, .TRAP_ADDR,
    .STATE_LEDS, .COUNT_ZERO_LED, .COUNT_NONZERO_FLAG);
  hpio_host_model hpio_host_model_inst (.ref_clk(REF_CLK),
    .out_rcvd_pulse(OUTPUT_DATA_RECEIVED_PULSE), .in_word_ready(INPUT_WORD_READY),
    .in_word(HOST_INPUT_WORD), .out_word(HOST_OUTPUT_WORD), .out_ctl(HOST_OUTPUT_CONTROL),
    .in_ctl(HOST_INPUT_CONTROL), .init(HOST_INIT));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  always @(posedge REF_CLK) begin
    cyc++;
    if (IRQ === 1'b1) irq_n++;
    if (OUTPUT_DATA_RECEIVED_PULSE === 1'b1) odr_n++;
    if (NEXT_DATA_READY_PULSE === 1'b1) next_data_ready_pulse_n++;
    if (cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end
  // memory stand-in for the block's master cycles; ack_lag models a slow target
  always begin
    @(posedge REF_CLK);
    #1;
    BUS_GRANT = BUS_REQUEST === 1'b1;
    if (BUS_ADDRESS_VALID_OUT !== 1'b1) begin
      BUS_ACKNOWLEDGE_IN = 1'b0;
      lag = ack_lag;
    end else if (lag > 0) lag--;
    else if (BUS_ACKNOWLEDGE_IN !== 1'b1) begin
      if (BUS_WRITE_OUT === 1'b1 && wn < 4) begin
        wa[wn] = BUS_ADDR_OUT;
        wd[wn] = BUS_DATA_OUT;
        wn++;
      end
      BUS_ACKNOWLEDGE_IN = 1'b1;
    end
  end
  task automatic acc(input logic w, input logic [1:0] sel, input logic [15:0] d,
    input logic [15:0] m, input logic [15:0] e);
    int n;
    logic [15:0] q;
    @(posedge REF_CLK);
    #1;
    BUS_ADDR_IN = {15'h7905, sel, 1'b0};
    BUS_DATA_IN = d;
    BUS_WRITE_IN = w;
    BUS_ADDRESS_VALID_IN = 1'b1;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (BUS_ACKNOWLEDGE_OUT !== 1'b1 && n < 20);
    q = BUS_DATA_OUT;
    #1;
    BUS_ADDRESS_VALID_IN = 1'b0;
    BUS_WRITE_IN = 1'b0;
    BUS_DATA_IN = ~d;
    chk("slave ack", 18'(n < 20), 18'h00001);
    if (m != 16'h0000) chk("reg read", {2'h0, q & m}, {2'h0, e});
  endtask : acc
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("state", 18'(STATE_LEDS), 18'h00000);
    chk("zero led", 18'(COUNT_ZERO_LED), 18'h00001);
    chk("iwr", 18'(INPUT_WORD_READY), 18'h00000);
    acc(1'b0, hpio_pkg::REG_ADDR, 16'h0000, 16'hFFFF, hpio_pkg::ADDR_RST);
    acc(1'b0, hpio_pkg::REG_COUNT, 16'h0000, 16'hFFFF, hpio_pkg::COUNT_RST);
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs();
    acc(1'b1, hpio_pkg::REG_COUNT, 16'h0003, 16'h0000, 16'h0000);
    acc(1'b0, hpio_pkg::REG_COUNT, 16'h0000, 16'hFFFF, 16'h0003);
    chk("nz flag", 18'(COUNT_NONZERO_FLAG), 18'h00001);
    chk("zero led", 18'(COUNT_ZERO_LED), 18'h00000);
    acc(1'b1, hpio_pkg::REG_ADDR, 16'hBEEE, 16'h0000, 16'h0000);
    acc(1'b0, hpio_pkg::REG_ADDR, 16'h0000, 16'hFFFF, 16'hBEEE);
    acc(1'b1, hpio_pkg::REG_COUNT, 16'h0000, 16'h0000, 16'h0000);
    acc(1'b1, hpio_pkg::REG_STAT, 16'hFFFF, 16'h0000, 16'h0000);
    // received bit written with the rest never sets: the clear wins in the same cycle, host output control being low
    acc(1'b0, hpio_pkg::REG_STAT, 16'h0000, hpio_pkg::ST_WR_MASK,
      hpio_pkg::ST_WR_MASK & 16'hFFDF);
    acc(1'b0, hpio_pkg::REG_STAT, 16'h0000, 16'h0110, 16'h0010);
    acc(1'b1, hpio_pkg::REG_STAT, 16'h0000, 16'h0000, 16'h0000);
    $display("test registers done");
  endtask : t_regs
  task automatic t_out();
    logic ok;
    int i0 = irq_n;
    int o0 = odr_n;
    acc(1'b1, hpio_pkg::REG_STAT, 16'h0040, 16'h0000, 16'h0000);
    hpio_host_model_inst.send(16'hA5C3, ok);
    chk("odr", 18'(ok), 18'h00001);
    repeat (4) @(posedge REF_CLK);
    chk("owr held", 18'(OUTPUT_WORD_RECEIVED), 18'h00001);
    chk("out irq", 18'(irq_n - i0), 18'h00001);
    chk("out trap", {9'h000, TRAP_ADDR}, {9'h000, hpio_pkg::TRAP_OUT});
    chk("out word", {2'h0, BUS_DATA_OUT}, 18'h0A5C3);
    hpio_host_model_inst.release_ctl();
    repeat (6) @(posedge REF_CLK);
    chk("owr drop", 18'(OUTPUT_WORD_RECEIVED), 18'h00000);
    chk("odr once", 18'(odr_n - o0), 18'h00001);
    chk("idle", 18'(STATE_LEDS), 18'h00000);
    $display("test single output done");
  endtask : t_out
  task automatic t_in();
    int i0 = irq_n;
    int n0 = next_data_ready_pulse_n;
    hpio_host_model_inst.in_lag = 5;
    acc(1'b1, hpio_pkg::REG_STAT, 16'h2000, 16'h0000, 16'h0000);
    acc(1'b1, hpio_pkg::REG_DATA, 16'h5A0F, 16'h0000, 16'h0000);
    for (int i = 0; i < 10 && INPUT_WORD_READY !== 1'b1; i++) @(posedge REF_CLK);
    chk("iwr", 18'(INPUT_WORD_READY), 18'h00001);
    chk("in word", {2'h0, HOST_INPUT_WORD}, 18'h05A0F);
    for (int i = 0; i < 40 && irq_n == i0; i++) @(posedge REF_CLK);
    chk("next_data_ready_pulse", 18'(next_data_ready_pulse_n - n0), 18'h00001);
    chk("iwr drop", 18'(INPUT_WORD_READY), 18'h00000);
    chk("in irq", 18'(irq_n - i0), 18'h00001);
    repeat (2) @(posedge REF_CLK);
    chk("in trap", {9'h000, TRAP_ADDR}, {9'h000, hpio_pkg::TRAP_IN});
    chk("host got", {2'h0, hpio_host_model_inst.got}, 18'h05A0F);
    acc(1'b1, hpio_pkg::REG_STAT, 16'h0000, 16'h0000, 16'h0000);
    $display("test single input done");
  endtask : t_in
  task automatic t_dma();
    logic ok;
    ack_lag = 8;
    acc(1'b1, hpio_pkg::REG_ADDR, 16'h0200, 16'h0000, 16'h0000);
    acc(1'b1, hpio_pkg::REG_COUNT, 16'h0003, 16'h0000, 16'h0000);
    acc(1'b1, hpio_pkg::REG_STAT, 16'h0800, 16'h0000, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      hpio_host_model_inst.send(16'h1111 * 16'(i + 1), ok);
      chk("dma odr", 18'(ok), 18'h00001);
      hpio_host_model_inst.release_ctl();
      repeat (3) @(posedge REF_CLK);
    end
    for (int i = 0; i < 200 && wn < 3; i++) @(posedge REF_CLK);
    chk("dma writes", 18'(wn), 18'h00003);
    for (int i = 0; i < 3; i++) begin
      chk("dma addr", wa[i], 18'h00200 + 18'(2 * i));
      chk("dma data", {2'h0, wd[i]}, {2'h0, 16'h1111 * 16'(i + 1)});
    end
    repeat (4) @(posedge REF_CLK);
    acc(1'b0, hpio_pkg::REG_COUNT, 16'h0000, 16'hFFFF, 16'h0000);
    acc(1'b0, hpio_pkg::REG_ADDR, 16'h0000, 16'hFFFF, 16'h0206);
    chk("zero led", 18'(COUNT_ZERO_LED), 18'h00001);
    acc(1'b1, hpio_pkg::REG_STAT, 16'h0000, 16'h0000, 16'h0000);
    $display("test dma output done");
  endtask : t_dma
  task automatic t_init();
    @(posedge REF_CLK);
    #1 hpio_host_model_inst.init = 1'b1;
    repeat (5) @(posedge REF_CLK);
    chk("init on", 18'(SYSTEM_RESET_REQ), 18'h00001);
    #1 hpio_host_model_inst.init = 1'b0;
    repeat (5) @(posedge REF_CLK);
    chk("init off", 18'(SYSTEM_RESET_REQ), 18'h00000);
    #1 HOST_POL_LOW = 1'b1;
    repeat (5) @(posedge REF_CLK);
    chk("init inverted", 18'(SYSTEM_RESET_REQ), 18'h00001);
    $display("test init done");
  endtask : t_init
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge REF_CLK);
    #1 RESETN = 1'b1;
    repeat (4) @(posedge REF_CLK);
    t_reset();
    t_regs();
    t_out();
    t_in();
    t_dma();
    t_init();
    close_out();
  end
endmodule : testbench

/* verilog/hpio_pkg.sv */
package hpio_pkg;
  // register select by processor address bits 2:1
  localparam logic [1:0] REG_COUNT = 2'h0;
  localparam logic [1:0] REG_ADDR = 2'h1;
  localparam logic [1:0] REG_STAT = 2'h2;
  localparam logic [1:0] REG_DATA = 2'h3;
  // status fields
  localparam int ST_MODE_IN = 3;
  localparam int ST_DMA_DONE = 4;
  localparam int ST_OWR = 5;
  localparam int ST_EN_OUT = 6;
  localparam int ST_SYNC_OUT = 7;
  localparam int ST_CNT_NZ = 8;
  localparam int ST_DMA_GO = 11;
  localparam int ST_EN_IN = 13;
  localparam logic [15:0] ST_WR_MASK = 16'h686F;
  localparam logic [15:0] ST_RST = 16'h0000;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  // trap vectors, first card
  localparam logic [8:0] TRAP_IN = 9'h050;
  localparam logic [8:0] TRAP_OUT = 9'h054;
  localparam int BUF_DEPTH = 2;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_OUT_GOT = 4'h1,
    S_OUT_WAIT = 4'h2,
    S_DMA_OREQ = 4'h3,
    S_DMA_OBUS = 4'h4,
    S_IN_LOAD = 4'h5,
    S_IN_READY = 4'h6,
    S_IN_DONE = 4'h7,
    S_DMA_IBUS = 4'h8,
    S_OUT_IRQ = 4'h9
  } hpio_state_t;
endpackage : hpio_pkg

/* verilog/hpio_port.sv */
`timescale 1ns/1ps
// Contract
// - host init becomes processor reset request
// - interrupt when host output word announced in single-word mode
// - single word to processor, DMA to memory
// - interrupt after host accepts single input word, or last DMA word
// - separate 16-bit words, own handshakes
// - internal bus muxes host, processor, registers
// - input register drives host input lines
// - address register drives DMA bus address
// - count register gives nonzero flag, zero LED
// - status mixes written and generated bits
// - decode address bits 2:1 with write, valid
// - write captures bus, read returns contents
// - state counter sequences every transfer
// - distinct sequences for in/out, single/DMA
// - state shown on four indicator outputs
// - master drives address, data, waits ack
// - slave steers data, returns acknowledge
// - interrupts from single words, DMA input end, and DMA output end if its last write is acked in S_DMA_OBUS
// - trap address identifies interrupt type
// - processor reset initialises every circuit except the buffer storage
// - status card clock clocks all logic
// - host signals active high inside card
// - output received level and data pulse
// - input ready, then next data pulse
// - reset clears registers, state zero
module hpio_port (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic [15:0] HOST_OUTPUT_WORD,
  input wire logic HOST_OUTPUT_CONTROL,
  input wire logic HOST_INPUT_CONTROL,
  input wire logic HOST_INIT,
  input wire logic HOST_POL_LOW,
  output logic [15:0] HOST_INPUT_WORD,
  output logic OUTPUT_WORD_RECEIVED,
  output logic OUTPUT_DATA_RECEIVED_PULSE,
  output logic INPUT_WORD_READY,
  output logic NEXT_DATA_READY_PULSE,
  output logic SYSTEM_RESET_REQ,
  input wire logic [17:0] BUS_ADDR_IN,
  input wire logic [15:0] BUS_DATA_IN,
  input wire logic BUS_WRITE_IN,
  input wire logic BUS_ADDRESS_VALID_IN,
  input wire logic BUS_ACKNOWLEDGE_IN,
  input wire logic BUS_GRANT,
  output logic BUS_REQUEST,
  output logic [17:0] BUS_ADDR_OUT,
  output logic [15:0] BUS_DATA_OUT,
  output logic BUS_DATA_OE,
  output logic BUS_MASTER_OE,
  output logic BUS_WRITE_OUT,
  output logic BUS_ADDRESS_VALID_OUT,
  output logic BUS_ACKNOWLEDGE_OUT,
  output logic IRQ,
  output logic [8:0] TRAP_ADDR,
  output logic [3:0] STATE_LEDS,
  output logic COUNT_ZERO_LED,
  output logic COUNT_NONZERO_FLAG
);
  ////////////////////////////////////////////////////////////////////
  // host pin synchronisers; polarity strap also synchronised
  logic [19:0] s1_ff;
  logic [19:0] s2_ff;
  logic [15:0] h_word;
  logic h_host_output_control;
  logic h_host_input_control;
  logic h_init;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s1_ff <= 20'h00000;
      s2_ff <= 20'h00000;
    end else begin
      s1_ff <= {HOST_POL_LOW, HOST_INIT, HOST_INPUT_CONTROL, HOST_OUTPUT_CONTROL,
                HOST_OUTPUT_WORD};
      s2_ff <= s1_ff;
    end
  end
  assign h_word = s2_ff[19] ? ~s2_ff[15:0] : s2_ff[15:0];
  assign h_host_output_control = s2_ff[19] ^ s2_ff[16];
  assign h_host_input_control = s2_ff[19] ^ s2_ff[17];
  assign h_init = s2_ff[19] ^ s2_ff[18];
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) SYSTEM_RESET_REQ <= 1'b0;
    else SYSTEM_RESET_REQ <= h_init;
  end
  ////////////////////////////////////////////////////////////////////
  // slave decode
  logic av_d_ff;
  logic sel;
  logic wr_cmd;
  logic rd_cmd;
  logic [1:0] rsel;
  assign sel = BUS_ADDRESS_VALID_IN && BUS_ADDR_IN[17:3] == 15'h7905 && !BUS_MASTER_OE;
  assign rsel = BUS_ADDR_IN[2:1];
  assign wr_cmd = sel && !av_d_ff && BUS_WRITE_IN;
  assign rd_cmd = sel && !av_d_ff && !BUS_WRITE_IN;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) av_d_ff <= 1'b0;
    else av_d_ff <= sel;
  end
  ////////////////////////////////////////////////////////////////////
  // registers
  hpio_pkg::hpio_state_t state_ff;
  logic [15:0] addr_ff;
  logic [15:0] count_ff;
  logic [15:0] stat_ff;
  logic [15:0] stat_rd;
  logic [15:0] in_ff;
  logic [15:0] io_bus;
  logic ack_ff;
  logic dma_step;
  logic owr_set;
  logic dma;
  // buffer storage and master flag are read by the data register below
  localparam int BUF_DEPTH_L = hpio_pkg::BUF_DEPTH;
  logic [15:0] buf_mem [BUF_DEPTH_L];
  logic buf_out_valid;
  logic mst_ff;
  assign dma = stat_ff[hpio_pkg::ST_DMA_GO];
  assign COUNT_NONZERO_FLAG = count_ff != 16'h0000;
  assign COUNT_ZERO_LED = !COUNT_NONZERO_FLAG;
  always_comb begin
    stat_rd = stat_ff & hpio_pkg::ST_WR_MASK;
    stat_rd[hpio_pkg::ST_SYNC_OUT] = h_host_output_control;
    stat_rd[hpio_pkg::ST_CNT_NZ] = COUNT_NONZERO_FLAG;
    stat_rd[hpio_pkg::ST_DMA_DONE] = !COUNT_NONZERO_FLAG;
  end
  always_comb begin
    io_bus = BUS_DATA_IN;
    if (rd_cmd) begin
      unique case (rsel)
        hpio_pkg::REG_COUNT: io_bus = count_ff;
        hpio_pkg::REG_ADDR: io_bus = addr_ff;
        hpio_pkg::REG_STAT: io_bus = stat_rd;
        hpio_pkg::REG_DATA: io_bus = in_ff;
      endcase
    end else if (state_ff == hpio_pkg::S_OUT_GOT || state_ff == hpio_pkg::S_DMA_OREQ) begin
      io_bus = h_word;
    end
  end
  // data out is registered from the mux; slave reads present on ack
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack_ff <= 1'b0;
      BUS_DATA_OUT <= 16'h0000;
    end else begin
      if (rd_cmd || wr_cmd) ack_ff <= 1'b1;
      else if (!sel) ack_ff <= 1'b0;
      if (rd_cmd || state_ff == hpio_pkg::S_OUT_GOT)
        BUS_DATA_OUT <= io_bus;
      // dma words leave the buffer head, so a stalled master loses none
      else if (buf_out_valid && !mst_ff)
        BUS_DATA_OUT <= buf_mem[buf_rp_ff];
    end
  end
  assign BUS_ACKNOWLEDGE_OUT = ack_ff;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) addr_ff <= hpio_pkg::ADDR_RST;
    else if (wr_cmd && rsel == hpio_pkg::REG_ADDR) addr_ff <= io_bus;
    else if (dma_step) addr_ff <= addr_ff + 16'h0002;
  end
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) count_ff <= hpio_pkg::COUNT_RST;
    else if (wr_cmd && rsel == hpio_pkg::REG_COUNT) count_ff <= io_bus;
    else if (dma_step && count_ff != 16'h0000) count_ff <= count_ff - 16'h0001;
  end
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      stat_ff <= hpio_pkg::ST_RST;
    end else begin
      if (wr_cmd && rsel == hpio_pkg::REG_STAT)
        stat_ff <= (io_bus & hpio_pkg::ST_WR_MASK) | (stat_ff & 16'h0020);
      if (owr_set) stat_ff[hpio_pkg::ST_OWR] <= 1'b1; // set beats clear
      else if (!h_host_output_control) stat_ff[hpio_pkg::ST_OWR] <= 1'b0;
    end
  end
  // host input register loads from processor write or from DMA read
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) in_ff <= 16'h0000;
    else if (wr_cmd && rsel == hpio_pkg::REG_DATA) in_ff <= io_bus;
    else if (state_ff == hpio_pkg::S_DMA_IBUS && BUS_ACKNOWLEDGE_IN) in_ff <= BUS_DATA_IN;
  end
  assign HOST_INPUT_WORD = in_ff;
  ////////////////////////////////////////////////////////////////////
  // two-entry buffer between host output capture and bus master
  logic [1:0] buf_cnt_ff;
  logic buf_wp_ff;
  logic buf_rp_ff;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_ready;
  assign buf_in_ready = buf_cnt_ff != 2'h2;
  assign buf_out_valid = buf_cnt_ff != 2'h0;
  assign buf_in_valid = state_ff == hpio_pkg::S_DMA_OREQ && !stat_ff[hpio_pkg::ST_OWR];
  always_ff @(posedge REF_CLK) begin
    if (buf_in_valid && buf_in_ready) buf_mem[buf_wp_ff] <= h_word;
  end
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      buf_cnt_ff <= 2'h0;
      buf_wp_ff <= 1'b0;
      buf_rp_ff <= 1'b0;
    end else begin
      if (buf_in_valid && buf_in_ready) buf_wp_ff <= ~buf_wp_ff;
      if (buf_out_valid && buf_out_ready) buf_rp_ff <= ~buf_rp_ff;
      buf_cnt_ff <= buf_cnt_ff + {1'b0, buf_in_valid && buf_in_ready}
                    - {1'b0, buf_out_valid && buf_out_ready};
    end
  end
  ////////////////////////////////////////////////////////////////////
  // bus master: one write per buffered word, one read per input word
  logic mst_av_ff;
  logic mst_rd;
  assign mst_rd = state_ff == hpio_pkg::S_DMA_IBUS;
  assign BUS_REQUEST = (buf_out_valid || mst_rd) && !mst_ff && !sel;
  assign buf_out_ready = mst_ff && !mst_rd && BUS_ACKNOWLEDGE_IN && mst_av_ff;
  assign dma_step = mst_ff && mst_av_ff && BUS_ACKNOWLEDGE_IN;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      mst_ff <= 1'b0;
      mst_av_ff <= 1'b0;
    end else if (!mst_ff) begin
      mst_ff <= BUS_REQUEST && BUS_GRANT;
    end else if (!mst_av_ff) begin
      mst_av_ff <= 1'b1;
    end else if (BUS_ACKNOWLEDGE_IN) begin
      mst_ff <= 1'b0;
      mst_av_ff <= 1'b0;
    end
  end
  assign BUS_MASTER_OE = mst_ff;
  assign BUS_ADDR_OUT = {stat_ff[2:1], addr_ff};
  assign BUS_WRITE_OUT = mst_ff && !mst_rd;
  assign BUS_ADDRESS_VALID_OUT = mst_av_ff;
  assign BUS_DATA_OE = (mst_ff && !mst_rd) || ack_ff && !BUS_WRITE_IN;
  ////////////////////////////////////////////////////////////////////
  // sequence counter
  logic irq_in;
  logic irq_out;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff <= hpio_pkg::S_IDLE;
    end else begin
      unique case (state_ff)
        hpio_pkg::S_IDLE:
          if (h_host_output_control) state_ff <= dma ? hpio_pkg::S_DMA_OREQ : hpio_pkg::S_OUT_IRQ;
          else if (wr_cmd && rsel == hpio_pkg::REG_DATA) state_ff <= hpio_pkg::S_IN_LOAD;
          else if (dma && stat_ff[hpio_pkg::ST_MODE_IN] && COUNT_NONZERO_FLAG)
            state_ff <= hpio_pkg::S_DMA_IBUS;
        hpio_pkg::S_OUT_IRQ: state_ff <= hpio_pkg::S_OUT_GOT;
        hpio_pkg::S_OUT_GOT: state_ff <= hpio_pkg::S_OUT_WAIT;
        hpio_pkg::S_OUT_WAIT: if (!h_host_output_control) state_ff <= hpio_pkg::S_IDLE;
        hpio_pkg::S_DMA_OREQ: if (buf_in_ready) state_ff <= hpio_pkg::S_DMA_OBUS;
        hpio_pkg::S_DMA_OBUS:
          if (!h_host_output_control) state_ff <= hpio_pkg::S_IDLE;
        hpio_pkg::S_DMA_IBUS: if (dma_step) state_ff <= hpio_pkg::S_IN_LOAD;
        hpio_pkg::S_IN_LOAD: state_ff <= hpio_pkg::S_IN_READY;
        hpio_pkg::S_IN_READY: if (h_host_input_control) state_ff <= hpio_pkg::S_IN_DONE;
        hpio_pkg::S_IN_DONE: if (!h_host_input_control) state_ff <= hpio_pkg::S_IDLE;
        default: state_ff <= hpio_pkg::S_IDLE;
      endcase
    end
  end
  assign STATE_LEDS = state_ff;
  // single-word output hands the word to the processor by loading BUS_DATA_OUT in S_OUT_GOT
  assign owr_set = state_ff == hpio_pkg::S_OUT_GOT || state_ff == hpio_pkg::S_DMA_OBUS;
  assign OUTPUT_WORD_RECEIVED = stat_ff[hpio_pkg::ST_OWR];
  assign INPUT_WORD_READY = state_ff == hpio_pkg::S_IN_READY;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      OUTPUT_DATA_RECEIVED_PULSE <= 1'b0;
      NEXT_DATA_READY_PULSE <= 1'b0;
    end else begin
      OUTPUT_DATA_RECEIVED_PULSE <= owr_set && !stat_ff[hpio_pkg::ST_OWR];
      NEXT_DATA_READY_PULSE <= INPUT_WORD_READY && h_host_input_control;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // interrupts: output on announce or on last DMA write acked in S_DMA_OBUS, input after host accepts a single or last DMA word
  assign irq_out = state_ff == hpio_pkg::S_OUT_IRQ ||
                   (state_ff == hpio_pkg::S_DMA_OBUS && dma_step && count_ff == 16'h0001);
  assign irq_in = state_ff == hpio_pkg::S_IN_DONE && !h_host_input_control &&
                  (!dma || count_ff == 16'h0000);
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      IRQ <= 1'b0;
      TRAP_ADDR <= 9'h000;
    end else if (irq_out && stat_ff[hpio_pkg::ST_EN_OUT]) begin
      IRQ <= 1'b1;
      TRAP_ADDR <= hpio_pkg::TRAP_OUT;
    end else if (irq_in && stat_ff[hpio_pkg::ST_EN_IN]) begin
      IRQ <= 1'b1;
      TRAP_ADDR <= hpio_pkg::TRAP_IN;
    end else begin
      IRQ <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////
  irq_out_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    state_ff == hpio_pkg::S_OUT_IRQ && stat_ff[hpio_pkg::ST_EN_OUT] |=> IRQ &&
    TRAP_ADDR == hpio_pkg::TRAP_OUT) else $error("output interrupt missing");
  input_ready_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    INPUT_WORD_READY && h_host_input_control |=> !INPUT_WORD_READY ##0 NEXT_DATA_READY_PULSE)
    else $error("input handshake wrong");
  owr_hold_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    OUTPUT_WORD_RECEIVED && h_host_output_control |=> OUTPUT_WORD_RECEIVED) else $error("owr dropped");
  odr_pulse_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    OUTPUT_DATA_RECEIVED_PULSE |=> !OUTPUT_DATA_RECEIVED_PULSE) else $error("odr too long");
  slave_ack_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    wr_cmd || rd_cmd |=> BUS_ACKNOWLEDGE_OUT) else $error("no slave ack");
  count_dec_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    dma_step && count_ff != 16'h0000 && !wr_cmd |=> count_ff == $past(count_ff) - 16'h0001)
    else $error("count not decremented");
  master_hold_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    BUS_ADDRESS_VALID_OUT && !BUS_ACKNOWLEDGE_IN |=> BUS_ADDRESS_VALID_OUT)
    else $error("address valid dropped early");
  leds_state_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    STATE_LEDS == state_ff) else $error("leds wrong");
  nz_flag_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    COUNT_NONZERO_FLAG != COUNT_ZERO_LED) else $error("count flag wrong");
  cov_single_out: cover property (@(posedge REF_CLK) state_ff == hpio_pkg::S_OUT_WAIT);
  cov_dma_out: cover property (@(posedge REF_CLK) state_ff == hpio_pkg::S_DMA_OBUS && dma_step);
  cov_input: cover property (@(posedge REF_CLK) NEXT_DATA_READY_PULSE);
  cov_buf_full: cover property (@(posedge REF_CLK) buf_cnt_ff == 2'h2);
  cov_dma_in: cover property (@(posedge REF_CLK) state_ff == hpio_pkg::S_DMA_IBUS);
  ////////////////////////////////////////////////////////////////////
  // host init must reach the processor within the sync delay
  init_req_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    h_init |=> SYSTEM_RESET_REQ)
    else $error("reset request missing");
  // every interrupt carries one of the two known vectors
  trap_type_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    IRQ |-> (TRAP_ADDR == hpio_pkg::TRAP_IN || TRAP_ADDR == hpio_pkg::TRAP_OUT))
    else $error("unknown trap vector");
  // received flag only lives while the host holds output control
  owr_clear_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    !h_host_output_control && !owr_set |=> !OUTPUT_WORD_RECEIVED)
    else $error("owr stuck");
  next_data_ready_pulse_pulse_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    NEXT_DATA_READY_PULSE |=> !NEXT_DATA_READY_PULSE)
    else $error("next_data_ready_pulse too long");
  // address valid without bus ownership would clash with another master
  master_own_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    BUS_ADDRESS_VALID_OUT |-> BUS_MASTER_OE)
    else $error("valid without bus");
  addr_step_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    dma_step && !wr_cmd |=> addr_ff == $past(addr_ff) + 16'h0002)
    else $error("address not stepped");
  // slave must stay deaf to its own master cycles
  slave_refuse_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    BUS_MASTER_OE |-> !wr_cmd && !rd_cmd)
    else $error("slave decode while master");
  single_out_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    state_ff == hpio_pkg::S_OUT_GOT |=> BUS_DATA_OUT == $past(h_word))
    else $error("single word not presented");
  // two entries only; a third would overwrite an unsent word
  buf_limit_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    buf_cnt_ff != 2'h3)
    else $error("buffer overrun");
endmodule : hpio_port
